// *** pfd_chk.sv ***
`timescale 1ns/1ns
module pfd_chk
   import pfd_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Memory and power
   input wire logic [11:0] pmem_addr,
   input wire logic [11:0] pmem_data,
   input wire logic osc_stop
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic wr_i;
   assign wr_i = psel && penable && pready && pwrite && paddr == REG_INSTR;
   property p_rdy; psel && !penable |=> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("no ready after setup");
   property p_one; pready |-> psel && penable && $past(psel && !penable); endproperty
   a_one: assert property (p_one) else $error("ready outside access");
   property p_err; psel && !penable && !pwrite && paddr > 8'h20 |=> pslverr && prdata == 32'h0;
   endproperty
   a_err: assert property (p_err) else $error("unmapped read not refused");
   property p_ok; psel && !penable && paddr <= 8'h20 && paddr[1:0] == 2'h0 |=> !pslverr;
   endproperty
   a_ok: assert property (p_ok) else $error("error on mapped address");
   property p_halt; osc_stop |=> osc_stop; endproperty
   a_halt: assert property (p_halt) else $error("oscillator restarted");
   property p_sleep; $rose(osc_stop) |-> $past(wr_i && pwdata[11:0] == OPC_SLEEP); endproperty
   a_sleep: assert property (p_sleep) else $error("stop without power down");
   property p_fetch; !$stable(pmem_addr) |-> $past(wr_i && pwdata[11:0] == OPC_PM_FETCH);
   endproperty
   a_fetch: assert property (p_fetch) else $error("fetch address moved");
   property p_drop; pready |=> !pready; endproperty
   a_drop: assert property (p_drop) else $error("ready held");
endmodule : pfd_chk

bind pfd_decoder pfd_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .pmem_addr(pmem_addr), .pmem_data(pmem_data),
   .osc_stop(osc_stop));

// *** pfd_cycle_timer.sv ***
`timescale 1ns/1ns
module pfd_cycle_timer
   import pfd_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Start request
   input wire logic start,
   input wire logic [pfd_pkg::CYC_W-1:0] cycles,
   // Status
   output logic busy,
   output logic done
);
   logic [CYC_W-1:0] left_r;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         left_r <= '0;
      else if (start)
         left_r <= cycles;
      else if (left_r != '0)
         left_r <= left_r - CYC_ONE;
   end

   assign busy = (left_r != '0);
   assign done = (left_r == CYC_ONE);
endmodule : pfd_cycle_timer

// *** pfd_decoder.sv ***
`timescale 1ns/1ns
module pfd_decoder
   import pfd_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Program memory read port
   output logic [11:0] pmem_addr,
   input wire logic [11:0] pmem_data,
   // Power control
   output logic osc_stop
);
   import pfd_pkg::*;

   logic turbo_r;
   logic [11:0] instr_r;
   logic [PC_W-1:0] pc_r;
   logic [PC_W-1:0] stack_r [STK_DEPTH];
   logic [SP_W-1:0] sp_r;
   pfd_ctx_s ctx_r;
   pfd_ctx_s shadow_r;
   logic [PC_W-1:0] shpc_r;
   logic [3:0] mode_r;
   logic [7:0] timer_r;
   logic [7:0] wdog_r;
   logic [7:0] fdata_r;
   logic halt_r;
   logic fetch_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic [11:0] pmem_addr_r;

   logic wr_acc;
   logic issue;
   logic busy;
   logic done;
   pfd_op_e op;
   logic [CYC_W-1:0] cyc;
   logic skip_take;
   logic [7:0] test_val;
   logic [PC_W-1:0] pc_nxt;
   logic [PC_W-1:0] pc_inc;
   logic [PC_W-1:0] tos;
   logic [1:0] page;
   logic mapped;
   logic [31:0] rdata_nxt;

   assign wr_acc = psel && penable && pready_r && pwrite;
   assign issue = wr_acc && (paddr == REG_INSTR) && !busy && !halt_r;
   assign pc_inc = pc_r + PC_W'(1);
   assign tos = stack_r[sp_r - SP_W'(1)];
   assign page = ctx_r.status[ST_PAGE_LO+1:ST_PAGE_LO];

   pfd_cycle_timer u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .start(issue),
      .cycles(cyc),
      .busy(busy),
      .done(done)
   );

   // Operand of a bit test: pc and status are local, other files come from software
   always_comb
   begin
      test_val = fdata_r;
      if (pwdata[4:0] == FILE_PC)
         test_val = pc_r[7:0];
      else if (pwdata[4:0] == FILE_STATUS)
         test_val = ctx_r.status;
   end

   // Decode and cost
   always_comb
   begin
      op = OP_NOP;
      cyc = CYC_ONE;
      skip_take = 1'b0;
      if ((pwdata[11:0] & OPC_HI4_M) == OPC_CALL_V)
      begin
         op = OP_CALL;
         cyc = turbo_r ? CYC_FLOW_T : CYC_FLOW_C;
      end
      else if ((pwdata[11:0] & OPC_JUMP_M) == OPC_JUMP_V)
      begin
         op = OP_JUMP;
         cyc = turbo_r ? CYC_FLOW_T : CYC_FLOW_C;
      end
      else if ((pwdata[11:0] & OPC_HI4_M) == OPC_LIT_EXIT_V)
      begin
         op = OP_LEXIT;
         cyc = turbo_r ? CYC_FLOW_T : CYC_FLOW_C;
      end
      else if ((pwdata[11:0] & OPC_SKIP_M) == OPC_SKIP_V)
      begin
         op = OP_SKIP;
         skip_take = (test_val[pwdata[7:5]] == pwdata[SKIP_SET_BIT]);
         if (!skip_take)
            cyc = CYC_ONE;
         else if (pwdata[4:0] == FILE_PC && pwdata[7:5] == 3'h0)
            cyc = turbo_r ? CYC_PCSKIP_T : CYC_PCSKIP_C;
         else
            cyc = CYC_SKIP;
      end
      else if ((pwdata[11:0] & OPC_BANK_M) == OPC_BANK_V)
         op = OP_BANK;
      else if ((pwdata[11:0] & OPC_BANK_M) == OPC_PAGE_V)
         op = OP_PAGE;
      else
      begin
         case (pwdata[11:0])
            OPC_SUB_EXIT:
            begin
               op = OP_SEXIT;
               cyc = turbo_r ? CYC_FLOW_T : CYC_FLOW_C;
            end
            OPC_PSUB_EXIT:
            begin
               op = OP_PEXIT;
               cyc = turbo_r ? CYC_FLOW_T : CYC_FLOW_C;
            end
            OPC_INT_EXIT:
            begin
               op = OP_IEXIT;
               cyc = turbo_r ? CYC_FLOW_T : CYC_FLOW_C;
            end
            OPC_INT_EXIT_TMR:
            begin
               op = OP_IEXIT_T;
               cyc = turbo_r ? CYC_FLOW_T : CYC_FLOW_C;
            end
            OPC_PM_FETCH:
            begin
               op = OP_FETCH;
               cyc = turbo_r ? CYC_FETCH_T : CYC_FETCH_C;
            end
            OPC_SLEEP:
               op = OP_SLEEP;
            OPC_PCMOV:
            begin
               op = OP_PCMOV;
               cyc = turbo_r ? CYC_PCW_T : CYC_PCW_C;
            end
            OPC_PCADD:
            begin
               op = OP_PCADD;
               cyc = turbo_r ? CYC_PCW_T : CYC_PCW_C;
            end
            default:
               op = OP_NOP;
         endcase
      end
   end

   // Next program counter
   always_comb
   begin
      case (op)
         OP_CALL:
            pc_nxt = {page, 1'b0, pwdata[7:0]};
         OP_JUMP:
            pc_nxt = {page, pwdata[8:0]};
         OP_SEXIT, OP_PEXIT, OP_LEXIT:
            pc_nxt = tos;
         OP_IEXIT, OP_IEXIT_T:
            pc_nxt = shpc_r;
         OP_PCMOV:
            pc_nxt = {page, 1'b0, ctx_r.w};
         OP_PCADD:
            pc_nxt = {page, 1'b0, 8'(pc_r[7:0] + ctx_r.w)};
         OP_SKIP:
            pc_nxt = skip_take ? pc_r + PC_W'(2) : pc_inc;
         default:
            pc_nxt = pc_inc;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pc_r <= '0;
      else if (issue)
         pc_r <= pc_nxt;
   end

   // Hardware stack; wraps silently on overflow like a fixed-depth ring
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sp_r <= '0;
         for (int i = 0; i < STK_DEPTH; i++)
            stack_r[i] <= '0;
      end
      else if (issue && op == OP_CALL)
      begin
         stack_r[sp_r] <= pc_inc;
         sp_r <= sp_r + SP_W'(1);
      end
      else if (issue && (op == OP_SEXIT || op == OP_PEXIT || op == OP_LEXIT))
         sp_r <= sp_r - SP_W'(1);
   end

   // Accumulator, status and file pointer
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctx_r <= '{fsp: 8'h00, status: STATUS_RST, w: 8'h00};
      else if (fetch_r && done)
         ctx_r.w <= pmem_data[7:0];
      else if (issue)
      begin
         case (op)
            OP_IEXIT, OP_IEXIT_T:
               ctx_r <= shadow_r;
            OP_LEXIT:
               ctx_r.w <= pwdata[7:0];
            OP_PEXIT:
               ctx_r.status[ST_PAGE_LO+1:ST_PAGE_LO] <= tos[PC_W-1:PC_W-2];
            OP_BANK:
               ctx_r.fsp[7:5] <= pwdata[2:0];
            OP_PAGE:
               ctx_r.status[7:5] <= pwdata[2:0];
            OP_SLEEP:
            begin
               ctx_r.status[ST_EXPIRY] <= 1'b1;
               ctx_r.status[ST_HALT] <= 1'b1;
            end
            default:
               ctx_r <= ctx_r;
         endcase
      end
   end

   // Program memory fetch: address presented at issue, word taken at completion
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fetch_r <= 1'b0;
         pmem_addr_r <= '0;
         mode_r <= '0;
      end
      else if (fetch_r && done)
      begin
         fetch_r <= 1'b0;
         mode_r <= pmem_data[11:8];
      end
      else if (issue && op == OP_FETCH)
      begin
         fetch_r <= 1'b1;
         pmem_addr_r <= {mode_r, ctx_r.w};
      end
   end

   // Timer; the subtraction uses the pre-restore accumulator
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         timer_r <= '0;
      else if (issue && op == OP_IEXIT_T)
         timer_r <= timer_r - ctx_r.w;
      else if (wr_acc && paddr == REG_TIMER)
         timer_r <= pwdata[7:0];
   end

   // Watchdog counts while running; power down clears it and halts until reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wdog_r <= '0;
         halt_r <= 1'b0;
      end
      else if (issue && op == OP_SLEEP)
      begin
         wdog_r <= '0;
         halt_r <= 1'b1;
      end
      else if (!halt_r)
         wdog_r <= wdog_r + 8'h01;
   end

   // Software writable configuration
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         turbo_r <= 1'b0;
         instr_r <= '0;
         shadow_r <= '0;
         shpc_r <= '0;
         fdata_r <= '0;
      end
      else if (wr_acc)
      begin
         case (paddr)
            REG_CTRL:
               turbo_r <= pwdata[0];
            REG_INSTR:
               instr_r <= issue ? pwdata[11:0] : instr_r;
            REG_SHADOW:
               shadow_r <= pwdata[23:0];
            REG_SHPC:
               shpc_r <= pwdata[PC_W-1:0];
            REG_FDATA:
               fdata_r <= pwdata[7:0];
            default:
               fdata_r <= fdata_r;
         endcase
      end
   end

   // Read mux
   always_comb
   begin
      mapped = 1'b1;
      rdata_nxt = '0;
      case (paddr)
         REG_CTRL:
            rdata_nxt = {31'h0, turbo_r};
         REG_INSTR:
            rdata_nxt = {20'h0, instr_r};
         REG_STAT:
            rdata_nxt = {25'h0, sp_r, 1'b0, fetch_r, halt_r, busy};
         REG_PC:
            rdata_nxt = {21'h0, pc_r};
         REG_CORE:
            rdata_nxt = {4'h0, mode_r, ctx_r};
         REG_TIMER:
            rdata_nxt = {16'h0, wdog_r, timer_r};
         REG_SHADOW:
            rdata_nxt = {8'h0, shadow_r};
         REG_SHPC:
            rdata_nxt = {21'h0, shpc_r};
         REG_FDATA:
            rdata_nxt = {24'h0, fdata_r};
         default:
            mapped = 1'b0;
      endcase
   end

   // No wait state: answer registered in setup, ready in the first access cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= '0;
      end
      else if (psel && !penable)
      begin
         pready_r <= 1'b1;
         pslverr_r <= !mapped;
         prdata_r <= pwrite ? 32'h0 : rdata_nxt;
      end
      else
      begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign pmem_addr = pmem_addr_r;
   assign osc_stop = halt_r;
endmodule : pfd_decoder

// *** pfd_pkg.sv ***
package pfd_pkg;
   localparam int PC_W = 11;
   localparam int STK_DEPTH = 8;
   localparam int SP_W = 3;
   localparam int CYC_W = 3;

   // Opcode patterns, 12-bit instruction words
   localparam logic [11:0] OPC_NOP = 12'h000;
   localparam logic [11:0] OPC_SLEEP = 12'h003;
   localparam logic [11:0] OPC_SUB_EXIT = 12'h00C;
   localparam logic [11:0] OPC_PSUB_EXIT = 12'h00D;
   localparam logic [11:0] OPC_INT_EXIT = 12'h00E;
   localparam logic [11:0] OPC_INT_EXIT_TMR = 12'h00F;
   localparam logic [11:0] OPC_PM_FETCH = 12'h041;
   localparam logic [11:0] OPC_PCMOV = 12'h022;
   localparam logic [11:0] OPC_PCADD = 12'h1E2;
   localparam logic [11:0] OPC_BANK_M = 12'hFF8;
   localparam logic [11:0] OPC_BANK_V = 12'h018;
   localparam logic [11:0] OPC_PAGE_V = 12'h010;
   localparam logic [11:0] OPC_HI4_M = 12'hF00;
   localparam logic [11:0] OPC_CALL_V = 12'h900;
   localparam logic [11:0] OPC_LIT_EXIT_V = 12'h800;
   localparam logic [11:0] OPC_JUMP_M = 12'hE00;
   localparam logic [11:0] OPC_JUMP_V = 12'hA00;
   localparam logic [11:0] OPC_SKIP_M = 12'hE00;
   localparam logic [11:0] OPC_SKIP_V = 12'h600;
   localparam int SKIP_SET_BIT = 8;
   localparam logic [4:0] FILE_PC = 5'h02;
   localparam logic [4:0] FILE_STATUS = 5'h03;

   // Status layout
   localparam int ST_PAGE_LO = 5;
   localparam int ST_EXPIRY = 4;
   localparam int ST_HALT = 3;
   localparam logic [7:0] STATUS_RST = 8'h00;

   // Cycle costs, compatible and turbo
   localparam logic [CYC_W-1:0] CYC_ONE = 3'h1;
   localparam logic [CYC_W-1:0] CYC_FLOW_C = 3'h2;
   localparam logic [CYC_W-1:0] CYC_FLOW_T = 3'h3;
   localparam logic [CYC_W-1:0] CYC_FETCH_C = 3'h1;
   localparam logic [CYC_W-1:0] CYC_FETCH_T = 3'h4;
   localparam logic [CYC_W-1:0] CYC_PCW_C = 3'h4;
   localparam logic [CYC_W-1:0] CYC_PCW_T = 3'h3;
   localparam logic [CYC_W-1:0] CYC_SKIP = 3'h2;
   localparam logic [CYC_W-1:0] CYC_PCSKIP_C = 3'h4;
   localparam logic [CYC_W-1:0] CYC_PCSKIP_T = 3'h2;

   // APB register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_INSTR = 8'h04;
   localparam logic [7:0] REG_STAT = 8'h08;
   localparam logic [7:0] REG_PC = 8'h0C;
   localparam logic [7:0] REG_CORE = 8'h10;
   localparam logic [7:0] REG_TIMER = 8'h14;
   localparam logic [7:0] REG_SHADOW = 8'h18;
   localparam logic [7:0] REG_SHPC = 8'h1C;
   localparam logic [7:0] REG_FDATA = 8'h20;

   typedef enum logic [3:0] {
      OP_NOP, OP_CALL, OP_JUMP, OP_SEXIT, OP_PEXIT, OP_IEXIT, OP_IEXIT_T, OP_LEXIT,
      OP_BANK, OP_PAGE, OP_FETCH, OP_SLEEP, OP_PCMOV, OP_PCADD, OP_SKIP
   } pfd_op_e;

   typedef struct packed {
      logic [7:0] fsp;
      logic [7:0] status;
      logic [7:0] w;
   } pfd_ctx_s;
endpackage : pfd_pkg

// *** pfd_pmem.sv ***
`timescale 1ns/1ns
module pfd_pmem
(
   // Fetch port
   input wire logic [11:0] addr,
   output logic [11:0] data
);
   // Scrambled so a wrong fetch address shows up
   assign data = ~{addr[5:0], addr[11:6]};
endmodule : pfd_pmem

// *** tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
   import pfd_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, osc_stop, err;
   logic [7:0] paddr, acc, st, fsp, tmr, shw, shs, shf, fdat;
   logic [31:0] pwdata, prdata, rd;
   logic [11:0] pmem_addr, pmem_data;
   logic [10:0] pc, shp;
   logic [10:0] stk [8];
   logic [3:0] mode;
   logic [2:0] sp;
   int bad_count = 0;
   int n_checks = 0;
   int cyc = 0;
   pfd_decoder DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pmem_addr(pmem_addr), .pmem_data(pmem_data), .osc_stop(osc_stop));
   pfd_pmem u_mem (.addr(pmem_addr), .data(pmem_data));
   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         bad_count++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : wrap_up
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   // One idle cycle between transfers keeps each signal to one update per step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic reset_dut();
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      {pc, sp, acc, st, fsp, mode, tmr, shw, shs, shf, shp, fdat} = '0;
      stk = '{default: '0};
   endtask : reset_dut
   task automatic exec(input logic [11:0] op);
      logic [7:0] v;
      v = (op[4:0] == 5'h02) ? pc[7:0] : (op[4:0] == 5'h03) ? st : fdat;
      pc = pc + 11'h001;
      casez (op)
         12'h00C, 12'h00D, 12'b1000_????_????:
         begin
            sp = sp - 3'h1;
            pc = stk[sp];
         end
         12'b1001_????_????:
         begin
            stk[sp] = pc;
            sp = sp + 3'h1;
            pc = {st[6:5], 1'b0, op[7:0]};
         end
         12'b101?_????_????: pc = {st[6:5], op[8:0]};
         12'h00E, 12'h00F:
         begin
            if (op[0]) tmr = tmr - acc;
            {acc, st, fsp, pc} = {shw, shs, shf, shp};
         end
         12'b0000_0001_1???: fsp[7:5] = op[2:0];
         12'b0000_0001_0???: st[7:5] = op[2:0];
         12'h003: st[4:3] = 2'h3;
         12'h041: {mode, acc} = ~{acc[5:0], mode, acc[7:6]};
         12'h022: pc = {st[6:5], 1'b0, acc};
         12'h1E2: pc = {st[6:5], 1'b0, 8'(v + acc)};
         12'b011?_????_????: if (v[op[7:5]] == op[8]) pc = pc + 11'h001;
         default: ;
      endcase
      if (op == OPC_PSUB_EXIT) st[6:5] = pc[10:9];
      if (op[11:8] == 4'h8) acc = op[7:0];
   endtask : exec
   task automatic idle();
      rd[0] = 1'b1;
      while (rd[0] === 1'b1) apb(1'b0, REG_STAT, 32'h0);
   endtask : idle
   task automatic run(input logic [11:0] op);
      apb(1'b1, REG_INSTR, {20'h0, op});
      exec(op);
      idle();
      chk({rd[31:2], 2'h0}, {25'h0, sp, 4'h0});
      apb(1'b0, REG_PC, 32'h0);
      chk(rd, {21'h0, pc});
      apb(1'b0, REG_CORE, 32'h0);
      chk(rd, {4'h0, mode, fsp, st, acc});
   endtask : run
   // Probe write lands one cycle too early, then just in time
   task automatic cost(input logic [11:0] op, input int n);
      for (int d = n - 3; d <= n - 2; d++)
         if (d >= 0)
         begin
            apb(1'b1, REG_INSTR, {20'h0, op});
            exec(op);
            repeat (d) @(posedge pclk);
            apb(1'b1, REG_INSTR, 32'h0);
            apb(1'b0, REG_INSTR, 32'h0);
            chk(rd, (d == n - 2) ? 32'h0 : {20'h0, op});
            if (d == n - 2) exec(12'h000);
            idle();
         end
   endtask : cost
   initial
   begin
      logic [31:0] r;
      logic [11:0] ops [9];
      ops = '{12'h9A5, 12'hA33, 12'h00C, 12'h00D, 12'h00E, 12'h00F, 12'h8C3, 12'h041, 12'h022};
      {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
      void'($urandom(98));
      reset_dut();
      for (int a = 0; a <= 32; a += 4)
         if (a != 8 && a != 20)
         begin
            apb(1'b0, 8'(a), 32'h0);
            chk(rd, 32'h0);
         end
      r = $urandom;
      {shf, shs, shw} = r[23:0];
      apb(1'b1, REG_SHADOW, {8'h0, r[23:0]});
      r = $urandom;
      {fdat, tmr, shp} = {r[31:16], r[10:0]};
      apb(1'b1, REG_SHPC, {21'h0, shp});
      apb(1'b1, REG_TIMER, {24'h0, tmr});
      apb(1'b1, REG_FDATA, {24'h0, fdat});
      run({9'h003, r[2:0]});
      run({9'h002, r[5:3]});
      run({4'h9, r[15:8]});
      run({4'h9, r[23:16]});
      run({9'h002, ~r[5:3]});
      run(OPC_PSUB_EXIT);
      run({3'h5, r[31:23]});
      run(OPC_SUB_EXIT);
      run({4'h8, r[7:0]});
      for (int i = 0; i < 6; i++)
         run({3'h3, r[i], r[i+:3], i[0] ? 5'h07 : 5'h03});
      run({3'h3, r[9], r[12:10], 5'h02});
      run(OPC_PM_FETCH);
      run(OPC_PCMOV);
      run(OPC_PCADD);
      run(12'h0C5);
      run(12'hC12);
      run(OPC_INT_EXIT);
      run(OPC_INT_EXIT_TMR);
      apb(1'b0, REG_TIMER, 32'h0);
      chk({24'h0, rd[7:0]}, {24'h0, tmr});
      for (int t = 0; t < 2; t++)
      begin
         reset_dut();
         apb(1'b1, REG_CTRL, 32'(t));
         foreach (ops[i])
            cost(ops[i], i > 7 ? 4 - t : i == 7 ? 1 + 3 * t : 2 + t);
         cost({3'h3, pc[0], 3'h0, 5'h02}, 4 - 2 * t);
         cost(12'h603, 2);
         cost(OPC_PCADD, 4 - t);
      end
      reset_dut();
      run(OPC_SLEEP);
      apb(1'b0, REG_TIMER, 32'h0);
      chk({24'h0, rd[15:8]}, 32'h0);
      chk({31'h0, osc_stop}, 32'h1);
      apb(1'b1, REG_INSTR, {20'h0, OPC_SUB_EXIT});
      apb(1'b0, REG_INSTR, 32'h0);
      chk(rd, {20'h0, OPC_SLEEP});
      apb(1'b0, 8'h40, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      wrap_up();
   end
endmodule : tb_top
